// ===== design/updown_wiper_step_control.sv
// Device end: wiper position counter with zero-crossing gating
// Function
// RULE1 - Ignore steps while select is low
// RULE2 - Select rise latches direction from step
// RULE3 - Direction fixed while select stays high
// RULE4 - Step rising edge moves one tap
// RULE5 - Select fall holds current position
// RULE6 - Reset loads tap 31, maximum attenuation
// RULE7 - Select high at reset means increment
// RULE8 - Low enable turns gating on
// RULE9 - Gated change applies at zero crossing
// RULE10 - Gated change applies after 50ms timeout
// RULE11 - Host idles all inputs low
// RULE12 - Five-bit code spans taps 0 to 31
// RULE13 - Counter saturates at both ends
// RULE14 - Increment raises code, decrement lowers
`timescale 1ns/1ps
module updown_wiper_step_control #(
	parameter int unsigned TIMEOUT_CYC = updown_wiper_pkg::ZC_TIMEOUT_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	updown_wiper_if.device  link,
	input  wire logic       zero_cross_i,
	output logic [4:0]      position_o,
	output logic [4:0]      wiper_o,
	output logic            change_pending_o,
	output logic            increment_mode_o
);

	// ----------------------------------------------------------------
	// Edge detection
	// ----------------------------------------------------------------
	logic select_q;
	logic step_q;
	logic sel_rise;
	logic step_rise;

	// Previous levels start high so that a select already high at
	// reset is not mistaken for a fresh rising edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			select_q <= 1'b1;
			step_q   <= 1'b1;
		end else begin
			select_q <= link.select;
			step_q   <= link.step;
		end
	end

	assign sel_rise  = link.select && !select_q;
	assign step_rise = link.select && select_q && link.step && !step_q; // RULE1

	// ----------------------------------------------------------------
	// Direction latch
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			increment_mode_o <= 1'b1; // RULE7
		end else if (sel_rise) begin
			increment_mode_o <= link.step; // RULE2 RULE3
		end
	end

	// ----------------------------------------------------------------
	// Position counter
	// ----------------------------------------------------------------
	logic [4:0] next_position;

	always_comb begin
		next_position = position_o;
		if (step_rise) begin // RULE4
			if (increment_mode_o) begin
				if (position_o != updown_wiper_pkg::TAP_MAX) begin // RULE13
					next_position = position_o + 5'h01; // RULE14
				end
			end else begin
				if (position_o != updown_wiper_pkg::TAP_MIN) begin // RULE13
					next_position = position_o - 5'h01; // RULE14
				end
			end
		end
	end

	// Counter only moves on steps, so select low simply holds it
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			position_o <= updown_wiper_pkg::TAP_RESET; // RULE6 RULE12
		end else begin
			position_o <= next_position; // RULE5
		end
	end

	// ----------------------------------------------------------------
	// Zero-crossing gating
	// ----------------------------------------------------------------
	logic [21:0] zc_count;
	logic        timeout_hit;

	assign change_pending_o = (wiper_o != position_o);
	assign timeout_hit = (zc_count >= 22'(TIMEOUT_CYC - 1));

	// Timeout restarts only once the wiper catches up, so a burst of
	// steps cannot stretch the wait beyond one timeout period
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			zc_count <= 22'h000000;
		end else if (!change_pending_o || link.zero_cross_enable_n) begin
			zc_count <= 22'h000000;
		end else if (!timeout_hit) begin
			zc_count <= zc_count + 22'h000001;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wiper_o <= updown_wiper_pkg::TAP_RESET; // RULE6
		end else if (link.zero_cross_enable_n) begin
			wiper_o <= position_o; // RULE8
		end else if (change_pending_o && zero_cross_i) begin
			wiper_o <= position_o; // RULE9
		end else if (change_pending_o && timeout_hit) begin
			wiper_o <= position_o; // RULE10
		end
	end

endmodule

// ===== design/updown_wiper_pkg.sv
// Package with shared constants and types for the stepped attenuator link
package updown_wiper_pkg;

	// ----------------------------------------------------------------
	// Tap code
	// ----------------------------------------------------------------
	localparam int unsigned TAP_W     = 5;
	localparam logic [4:0]  TAP_MAX   = 5'h1f;
	localparam logic [4:0]  TAP_MIN   = 5'h00;
	localparam logic [4:0]  TAP_RESET = 5'h1f;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 50000000;
	localparam int unsigned ZC_TIMEOUT_MS = 50;
	localparam int unsigned ZC_TIMEOUT_CYC =
		(CLK_HZ / 1000) * ZC_TIMEOUT_MS;
	localparam int unsigned ZC_CNT_W = 22;
	// Host phase length, keeps each pin level for several clocks
	localparam int unsigned HOST_PHASE_CYC = 4;

	typedef enum logic [3:0] {
		H_IDLE  = 4'h1,
		H_SEL   = 4'h2,
		H_HIGH  = 4'h4,
		H_LOW   = 4'h8
	} host_state_t;

endpackage

// ===== design/updown_wiper_if.sv
// Interface joining the host and the attenuator control
`timescale 1ns/1ps
interface updown_wiper_if;
	logic select;
	logic step;
	logic zero_cross_enable_n;

	modport host (
		output select,
		output step,
		output zero_cross_enable_n
	);
	modport device (
		input  select,
		input  step,
		input  zero_cross_enable_n
	);
endinterface

// ===== design/updown_wiper_host.sv
// Host end: turns step requests into select and step pin sequences
`timescale 1ns/1ps
module updown_wiper_host (
	input  wire logic      clk_i,
	input  wire logic      rst_n_i,
	updown_wiper_if.host   link,
	input  wire logic      req_valid_i,
	input  wire logic      req_up_i,
	input  wire logic [4:0] req_count_i,
	input  wire logic      zc_gate_i,
	output logic           req_ready_o,
	output logic           busy_o
);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	updown_wiper_pkg::host_state_t state;
	logic [2:0] phase;
	logic [4:0] remain;
	logic       up;
	logic       gate;

	assign req_ready_o = (state == updown_wiper_pkg::H_IDLE);
	assign busy_o      = !req_ready_o;

	// Gating level is sampled per request; idle keeps it low
	assign link.zero_cross_enable_n = busy_o && !gate; // RULE8 RULE11

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state       <= updown_wiper_pkg::H_IDLE;
			phase       <= 3'h0;
			remain      <= 5'h00;
			up          <= 1'b0;
			gate        <= 1'b0;
			link.select <= 1'b0;
			link.step   <= 1'b0;
		end else begin
			phase <= phase + 3'h1;
			unique case (state)
				updown_wiper_pkg::H_IDLE: begin
					link.select <= 1'b0; // RULE11
					link.step   <= 1'b0; // RULE11
					phase       <= 3'h0;
					if (req_valid_i && req_count_i != 5'h00) begin
						up        <= req_up_i;
						gate      <= zc_gate_i;
						remain    <= req_count_i;
						link.step <= req_up_i; // RULE2
						state     <= updown_wiper_pkg::H_SEL;
					end
				end
				updown_wiper_pkg::H_SEL: begin
					if (phase == 3'(updown_wiper_pkg::HOST_PHASE_CYC - 1)) begin
						link.select <= 1'b1; // RULE2
						phase       <= 3'h0;
						state       <= updown_wiper_pkg::H_LOW;
					end
				end
				updown_wiper_pkg::H_LOW: begin
					if (phase == 3'(updown_wiper_pkg::HOST_PHASE_CYC - 1)) begin
						phase <= 3'h0;
						if (remain == 5'h00) begin
							link.select <= 1'b0;
							state       <= updown_wiper_pkg::H_IDLE;
						end else if (link.step) begin
							link.step <= 1'b0;
						end else begin
							link.step <= 1'b1; // RULE4
							remain    <= remain - 5'h01;
							state     <= updown_wiper_pkg::H_HIGH;
						end
					end
				end
				updown_wiper_pkg::H_HIGH: begin
					if (phase == 3'(updown_wiper_pkg::HOST_PHASE_CYC - 1)) begin
						link.step <= 1'b0;
						phase     <= 3'h0;
						state     <= updown_wiper_pkg::H_LOW;
					end
				end
				default: begin
					state <= updown_wiper_pkg::H_IDLE;
				end
			endcase
		end
	end

endmodule

// ===== test/updown_wiper_asserts.sv
// Concurrent checks on the link pins and the device outputs
`timescale 1ns/1ps
module updown_wiper_asserts #(
	parameter int unsigned TIMEOUT_CYC = 20
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       select,
	input  wire logic       step,
	input  wire logic       zero_cross_enable_n,
	input  wire logic       zero_cross_i,
	input  wire logic [4:0] position_o,
	input  wire logic [4:0] wiper_o,
	input  wire logic       change_pending_o,
	input  wire logic       increment_mode_o
);
	int        pend_cnt;
	wire logic gated = !zero_cross_enable_n && change_pending_o;
	// Counts how long a gated change has waited
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			pend_cnt <= 0;
		else
			pend_cnt <= gated ? pend_cnt + 1 : 0;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_idle_hold_pos: assert property (!select |=> $stable(position_o))
		else $error("position moved while idle");
	a_dir_latch: assert property ($rose(select) |=>
		increment_mode_o == $past(step)) else $error("wrong direction");
	a_dir_fixed: assert property (select && $past(select) |=>
		$stable(increment_mode_o)) else $error("direction changed");
	a_step_one_tap: assert property (select && $past(select) && $rose(step)
		&& position_o != (increment_mode_o ? 5'h1f : 5'h00) |=>
		position_o == (increment_mode_o ? $past(position_o) + 5'h01
		: $past(position_o) - 5'h01)) else $error("step not one tap");
	a_end_saturate: assert property (
		position_o == (increment_mode_o ? 5'h1f : 5'h00) |=>
		$stable(position_o)) else $error("counter wrapped");
	a_ungated_follow: assert property (zero_cross_enable_n |=>
		wiper_o == $past(position_o)) else $error("wiper not applied");
	a_zc_apply: assert property (!zero_cross_enable_n && zero_cross_i
		|=> wiper_o == $past(position_o)) else $error("crossing missed");
	a_gated_hold: assert property (gated && !zero_cross_i
		&& pend_cnt + 1 < TIMEOUT_CYC |=> $stable(wiper_o))
		else $error("wiper changed early");
	a_timeout_bound: assert property (pend_cnt <= TIMEOUT_CYC + 2)
		else $error("timeout overrun");
endmodule

// ===== test/testbench.sv
// Self-checking bench for the host and device ends joined by the link
`timescale 1ns/1ps
module testbench;
	localparam int TO = 20;
	logic       clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic       req_valid_i = 1'b0;
	logic       req_up_i = 1'b0;
	logic [4:0] req_count_i = 5'h00;
	logic       zc_gate_i = 1'b0;
	logic       zero_cross_i = 1'b0;
	logic       zc_rand = 1'b0;
	logic       dev_rst_n = 1'b1;
	logic       req_ready_o, busy_o, change_pending_o, increment_mode_o;
	logic [4:0] position_o, wiper_o, exp_pos;
	logic [4:0] exp_q[$];
	int         bad_count = 0;
	int         cmp_count = 0;
	int         pos_m = 31;
	int         seed = 32'h0000a569;
	int         r;
	updown_wiper_if lnk();
	updown_wiper_step_control #(.TIMEOUT_CYC(TO)) updown_wiper_step_control_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i && dev_rst_n), .link(lnk),
		.zero_cross_i(zero_cross_i), .position_o(position_o), .wiper_o(wiper_o),
		.change_pending_o(change_pending_o), .increment_mode_o(increment_mode_o));
	updown_wiper_host updown_wiper_host_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .link(lnk), .req_valid_i(req_valid_i),
		.req_up_i(req_up_i), .req_count_i(req_count_i), .zc_gate_i(zc_gate_i),
		.req_ready_o(req_ready_o), .busy_o(busy_o));
	updown_wiper_asserts #(.TIMEOUT_CYC(TO)) updown_wiper_asserts_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i && dev_rst_n),
		.select(lnk.select), .step(lnk.step),
		.zero_cross_enable_n(lnk.zero_cross_enable_n),
		.zero_cross_i(zero_cross_i), .position_o(position_o), .wiper_o(wiper_o),
		.change_pending_o(change_pending_o), .increment_mode_o(increment_mode_o));
	always #10 clk_i = ~clk_i;
	// Sparse crossings so both the crossing and the timeout paths are hit
	always @(negedge clk_i) zero_cross_i <= zc_rand && ($random(seed) % 6 == 0);
	task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic idle(input int extra);
		// A hung host is left to the watchdog, which fails the run
		while (req_ready_o !== 1'b1) @(negedge clk_i);
		repeat (extra) @(negedge clk_i);
	endtask
	task automatic req(input logic up, input logic [4:0] n);
		// One idle cycle keeps two requests from sharing a time step
		idle(1);
		req_valid_i = 1'b1;
		req_up_i = up;
		req_count_i = n;
		@(negedge clk_i);
		req_valid_i = 1'b0;
		pos_m = up ? pos_m + n : pos_m - n;
		pos_m = pos_m > 31 ? 31 : (pos_m < 0 ? 0 : pos_m);
		if (n != 5'h00) exp_q.push_back(5'(pos_m));
	endtask
	always @(negedge busy_o) if (exp_q.size() != 0) begin
		@(negedge clk_i);
		exp_pos = exp_q.pop_front();
		chk(position_o, exp_pos);
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		complete_run();
	end
	initial begin
		repeat (6) @(negedge clk_i);
		rst_n_i = 1'b1;
		chk(position_o, 5'h1f);
		chk({4'h0, increment_mode_o}, 5'h01);
		req(1'b1, 5'h03);
		req(1'b0, 5'h04);
		repeat (updown_wiper_pkg::HOST_PHASE_CYC + 2) @(negedge clk_i);
		chk({4'h0, lnk.select}, 5'h01);
		chk({4'h0, increment_mode_o}, 5'h00);
		// Device-only reset with select held high: no edge, so increment
		dev_rst_n = 1'b0;
		@(negedge clk_i);
		dev_rst_n = 1'b1;
		chk({4'h0, increment_mode_o}, 5'h01);
		chk(position_o, 5'h1f);
		void'(exp_q.pop_back());
		exp_q.push_back(5'h1f);
		pos_m = 31;
		req(1'b0, 5'h05);
		req(1'b0, 5'h00);
		req(1'b0, 5'h1f);
		req(1'b1, 5'h01);
		idle(2);
		chk(wiper_o, 5'(pos_m));
		zc_gate_i = 1'b1;
		req(1'b1, 5'h02);
		idle(0);
		chk(wiper_o, 5'h01);
		idle(TO + 4);
		chk(wiper_o, 5'(pos_m));
		zc_rand = 1'b1;
		repeat (12) begin
			r = $random(seed);
			req(r[0], r[5:1]);
		end
		idle(0);
		zc_rand = 1'b0;
		idle(TO + 4);
		chk(wiper_o, 5'(pos_m));
		complete_run();
	end
endmodule
